// file: design/sss_exec.sv
// Execution block for subtract, nibble exchange, direction load and halt.
// Assumes an APB master on pclk; instructions are written one at a time into the
// instruction register and each runs through four phases Q1 to Q4 on pclk.
`timescale 1ns/100ps
module sss_exec
  import sss_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core state seen by the rest of the chip.
  output logic osc_stop,
  output logic [DIR_COUNT*8-1:0] port_dir
);

  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_Q1 = 5'b00010,
    PH_Q2 = 5'b00100,
    PH_Q3 = 5'b01000,
    PH_Q4 = 5'b10000
  } sss_phase_t;

  sss_phase_t phase;
  sss_dec_t dec;
  sss_flags_t flags;
  logic [13:0] ir;
  logic [7:0] acc;
  logic [7:0] opnd;
  logic [7:0] result;
  logic [2:0] res_flags;
  logic [7:0] file_mem [FILE_DEPTH];
  logic [7:0] dir_reg [DIR_COUNT];
  logic [7:0] wdt_count;
  logic [7:0] wdt_pre;
  logic asleep;
  logic busy;
  logic [7:0] sub_diff;
  logic sub_nb;
  logic sub_nhb;
  logic sub_zero;

  // APB decode.
  logic setup;
  logic access;
  logic wr_ok;
  logic sel_instr;
  logic sel_acc;
  logic sel_status;
  logic sel_wake;
  logic sel_wdt;
  logic sel_dir;
  logic sel_file;
  logic [1:0] dir_idx;
  logic [6:0] file_idx;
  logic refuse;
  logic [31:0] next_rdata;
  logic start;
  logic is_sub;
  logic to_acc;
  logic to_file;

  assign busy = (phase != PH_IDLE);
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign file_idx = paddr[8:2];
  assign sel_file = paddr[FILE_SEL_BIT] & (paddr[1:0] == 2'h0);
  assign sel_instr = (paddr == OFS_INSTR);
  assign sel_acc = (paddr == OFS_ACC);
  assign sel_status = (paddr == OFS_STATUS);
  assign sel_wake = (paddr == OFS_WAKE);
  assign sel_wdt = (paddr == OFS_WDT);
  assign sel_dir = (paddr == OFS_DIR) | (paddr == OFS_DIR + 10'h004)
                 | (paddr == OFS_DIR + 10'h008);
  assign dir_idx = 2'(paddr[3:2] - OFS_DIR[3:2]);

  // Writes other than to the wake register are refused while an instruction is in flight so that the
  // execution path owns every register it may touch; reads of mapped offsets are always served.
  always_comb begin
    refuse = 1'b0;
    if (!(sel_file | sel_instr | sel_acc | sel_status | sel_wake | sel_wdt | sel_dir)) begin
      refuse = 1'b1;
    end else if (pwrite) begin
      if (sel_wdt) begin
        refuse = 1'b1;
      end else if (!sel_wake && busy) begin
        refuse = 1'b1;
      end else if (sel_instr && asleep) begin
        refuse = 1'b1;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (sel_file) begin
      next_rdata = {24'h00_0000, file_mem[file_idx]};
    end else if (sel_instr) begin
      next_rdata = {18'h0_0000, ir};
    end else if (sel_acc) begin
      next_rdata = {24'h00_0000, acc};
    end else if (sel_status) begin
      next_rdata = {25'h000_0000, asleep, busy, flags};
    end else if (sel_wdt) begin
      next_rdata = {16'h0000, wdt_count, wdt_pre};
    end else if (sel_dir) begin
      next_rdata = {24'h00_0000, dir_reg[dir_idx]};
    end
  end

  // Read data and error are taken in the setup cycle and stand through access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= refuse;
    end
  end

  assign pready = 1'b1;
  assign wr_ok = access & pwrite & ~pslverr;
  assign start = wr_ok & sel_instr;

  // Phase sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= PH_IDLE;
    end else begin
      unique case (phase)
        PH_IDLE: phase <= start ? PH_Q1 : PH_IDLE;
        PH_Q1: phase <= PH_Q2;
        PH_Q2: phase <= PH_Q3;
        PH_Q3: phase <= PH_Q4;
        PH_Q4: phase <= PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir <= 14'h0000;
    end else if (start) begin
      ir <= pwdata[13:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec <= '{op: OP_NONE, dest: 1'b0, faddr: 7'h00, lit: 8'h00};
    end else if (phase == PH_Q1) begin
      dec <= sss_decode(ir);
    end
  end

  // Q2 reads the operand.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd <= 8'h00;
    end else if (phase == PH_Q2) begin
      opnd <= (dec.op == OP_LITSUB) ? dec.lit : file_mem[dec.faddr];
    end
  end

  sss_sub u_sub (
    .minuend(opnd),
    .subtrahend(acc),
    .diff(sub_diff),
    .no_borrow(sub_nb),
    .no_half_borrow(sub_nhb),
    .is_zero(sub_zero)
  );

  // Q3 processes the data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= 8'h00;
      res_flags <= 3'h0;
    end else if (phase == PH_Q3) begin
      result <= (dec.op == OP_SWAP) ? {opnd[3:0], opnd[7:4]} : sub_diff;
      res_flags <= {sub_zero, sub_nhb, sub_nb};
    end
  end

  assign is_sub = (dec.op == OP_LITSUB) | (dec.op == OP_REGSUB);
  assign to_acc = (phase == PH_Q4) & ((dec.op == OP_LITSUB)
                | (((dec.op == OP_REGSUB) | (dec.op == OP_SWAP)) & ~dec.dest));
  assign to_file = (phase == PH_Q4) & ((dec.op == OP_REGSUB) | (dec.op == OP_SWAP))
                 & dec.dest;

  // Q4 writes the destination.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= RST_ACC;
    end else if (to_acc) begin
      acc <= result;
    end else if (wr_ok && sel_acc) begin
      acc <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_mem[i] <= RST_FILE;
      end
    end else if (to_file) begin
      file_mem[dec.faddr] <= result;
    end else if (wr_ok && sel_file) begin
      file_mem[file_idx] <= pwdata[7:0];
    end
  end

  // The legacy load and the APB both reach the same direction registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DIR_COUNT; i++) begin
        dir_reg[i] <= RST_DIR;
      end
    end else if (phase == PH_Q4 && dec.op == OP_DIRLOAD) begin
      dir_reg[2'(dec.faddr[2:0] - DIR_FIRST)] <= acc;
    end else if (wr_ok && sel_dir) begin
      dir_reg[dir_idx] <= pwdata[7:0];
    end
  end

  always_comb begin
    for (int i = 0; i < DIR_COUNT; i++) begin
      port_dir[i*8 +: 8] = dir_reg[i];
    end
  end

  // Flags: only subtracts and status writes touch the arithmetic bits, only halt the power bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= RST_FLAGS;
    end else if (phase == PH_Q4 && is_sub) begin
      flags.result_null <= res_flags[2];
      flags.half_borrow <= res_flags[1];
      flags.borrow_not <= res_flags[0];
    end else if (phase == PH_Q4 && dec.op == OP_HALT) begin
      flags.timeout <= 1'b1;
      flags.power_down <= 1'b0;
    end else if (wr_ok && sel_status) begin
      flags.result_null <= pwdata[ST_NULL];
      flags.half_borrow <= pwdata[ST_HALF_BORROW];
      flags.borrow_not <= pwdata[ST_BORROW_NOT];
    end
  end

  // Sleep state stops the oscillator until software writes the wake register with bit 0 set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asleep <= 1'b0;
    end else if (phase == PH_Q4 && dec.op == OP_HALT) begin
      asleep <= 1'b1;
    end else if (wr_ok && sel_wake && pwdata[0]) begin
      asleep <= 1'b0;
    end
  end

  assign osc_stop = asleep;

  // Watchdog with prescaler; it is frozen during sleep because the oscillator stops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_pre <= RST_WDT;
      wdt_count <= RST_WDT;
    end else if (phase == PH_Q4 && dec.op == OP_HALT) begin
      wdt_pre <= RST_WDT;
      wdt_count <= RST_WDT;
    end else if (!asleep) begin
      wdt_pre <= wdt_pre + 8'h01;
      if (wdt_pre == 8'hFF) begin
        wdt_count <= wdt_count + 8'h01;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LITSUB_RESULT: assert property (
    phase == PH_Q1 && sss_decode(ir).op == OP_LITSUB
    |-> ##4 acc == 8'($past(ir[7:0], 4) - $past(acc, 4)))
    else $error("literal subtract result wrong");

  AST_LITSUB_DECODE: assert property (
    phase == PH_Q2 && ir[13:9] == 5'h1E |-> dec.op == OP_LITSUB)
    else $error("literal subtract not decoded");

  AST_FOUR_PHASES: assert property (
    phase == PH_Q1 |=> phase == PH_Q2 ##1 phase == PH_Q3 ##1 phase == PH_Q4
    ##1 phase == PH_IDLE)
    else $error("phase sequence broken");

  AST_SUB_KEEPS_POWER: assert property (
    phase == PH_Q4 && is_sub |=> $stable(flags.timeout) && $stable(flags.power_down))
    else $error("subtract touched power flags");

  AST_NONNEG_FLAGS: assert property (
    phase == PH_Q3 && is_sub && opnd >= acc
    |-> ##2 flags.borrow_not && flags.result_null == ($past(opnd, 2) == $past(acc, 2)))
    else $error("borrow or null wrong for non-negative result");

  AST_ZERO_FLAGS: assert property (
    phase == PH_Q4 && is_sub && result == 8'h00 |=> flags.result_null && flags.borrow_not)
    else $error("zero result flags wrong");

  AST_NEG_WRAP: assert property (
    phase == PH_Q3 && is_sub && opnd < acc
    |=> result == 8'($past(opnd) - $past(acc)) ##1 !flags.borrow_not)
    else $error("negative result wrong");

  AST_REGSUB_DEST: assert property (
    phase == PH_Q4 && dec.op == OP_REGSUB && dec.dest
    |=> file_mem[$past(dec.faddr)] == $past(result) && $stable(acc))
    else $error("register subtract destination wrong");

  AST_REGSUB_DECODE: assert property (
    phase == PH_Q2 && ir[13:8] == 6'h02 |-> dec.op == OP_REGSUB && dec.dest == ir[7])
    else $error("register subtract not decoded");

  AST_REGSUB_TIMING: assert property (
    phase == PH_Q1 && sss_decode(ir).op == OP_REGSUB && !ir[7]
    |-> ##1 $stable(acc) [*3] ##1 acc == result)
    else $error("register subtract wrote too early or not at all");

  AST_HALT_SLEEP: assert property (
    phase == PH_Q1 && ir == 14'h0063 |-> !asleep [*4] ##1 asleep)
    else $error("halt did not sleep in Q4");

  AST_HALT_EFFECTS: assert property (
    phase == PH_Q4 && dec.op == OP_HALT
    |=> flags.timeout && !flags.power_down && wdt_count == 8'h00 && wdt_pre == 8'h00)
    else $error("halt side effects wrong");

  AST_DIRLOAD: assert property (
    phase == PH_Q4 && dec.op == OP_DIRLOAD
    |=> dir_reg[2'($past(dec.faddr[2:0]) - 3'h5)] == $past(acc))
    else $error("direction load wrong");

  AST_DIR_APB: assert property (
    wr_ok && sel_dir |=> dir_reg[$past(dir_idx)] == $past(pwdata[7:0]))
    else $error("direction register write lost");

  AST_SWAP: assert property (
    phase == PH_Q3 && dec.op == OP_SWAP
    |=> result == {$past(opnd[3:0]), $past(opnd[7:4])} ##1 $stable(flags))
    else $error("nibble exchange wrong");

  COV_LITSUB_NEG: cover property (phase == PH_Q4 && dec.op == OP_LITSUB && !res_flags[0]);
  COV_REGSUB_FILE: cover property (to_file && dec.op == OP_REGSUB);
  COV_HALT_WAKE: cover property (asleep ##[1:20] !asleep);
  COV_REFUSED: cover property (access && pslverr && pwrite);

endmodule

// file: design/sss_pkg.sv
// Constants, carrier types and decode function for the subtract/swap/halt execution block.
// Assumes an APB master on pclk and one instruction issued at a time.
package sss_pkg;

  localparam int PADDR_W = 10;
  localparam int FILE_DEPTH = 128;
  localparam int DIR_COUNT = 3;

  // Byte offsets on the APB.
  localparam logic [9:0] OFS_INSTR = 10'h000;
  localparam logic [9:0] OFS_ACC = 10'h004;
  localparam logic [9:0] OFS_STATUS = 10'h008;
  localparam logic [9:0] OFS_WAKE = 10'h00C;
  localparam logic [9:0] OFS_WDT = 10'h010;
  localparam logic [9:0] OFS_DIR = 10'h014;
  localparam logic [9:0] OFS_FILE = 10'h200;
  localparam int FILE_SEL_BIT = 9;

  // Status register bit positions.
  localparam int ST_BORROW_NOT = 0;
  localparam int ST_HALF_BORROW = 1;
  localparam int ST_NULL = 2;
  localparam int ST_POWER_DOWN = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_ASLEEP = 6;

  // Values after reset.
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_FILE = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_WDT = 8'h00;
  // Order is timeout, power_down, result_null, half_borrow, borrow_not.
  localparam logic [4:0] RST_FLAGS = 5'h18;

  // Instruction encodings.
  localparam logic [4:0] ENC_LITSUB = 5'h1E;
  localparam logic [5:0] ENC_REGSUB = 6'h02;
  localparam logic [5:0] ENC_SWAP = 6'h0E;
  localparam logic [13:0] ENC_HALT = 14'h0063;
  localparam logic [10:0] ENC_DIRLOAD = 11'h00C;
  localparam logic [2:0] DIR_FIRST = 3'h5;
  localparam logic [2:0] DIR_LAST = 3'h7;

  typedef enum logic [5:0] {
    OP_NONE = 6'b000001,
    OP_LITSUB = 6'b000010,
    OP_REGSUB = 6'b000100,
    OP_SWAP = 6'b001000,
    OP_HALT = 6'b010000,
    OP_DIRLOAD = 6'b100000
  } sss_op_t;

  typedef struct packed {
    sss_op_t op;
    logic dest;
    logic [6:0] faddr;
    logic [7:0] lit;
  } sss_dec_t;

  typedef struct packed {
    logic timeout;
    logic power_down;
    logic result_null;
    logic half_borrow;
    logic borrow_not;
  } sss_flags_t;

  function automatic sss_dec_t sss_decode(input logic [13:0] iw);
    sss_dec_t d;
    d.op = OP_NONE;
    d.dest = iw[7];
    d.faddr = iw[6:0];
    d.lit = iw[7:0];
    if (iw[13:9] == ENC_LITSUB) begin
      d.op = OP_LITSUB;
    end else if (iw[13:8] == ENC_REGSUB) begin
      d.op = OP_REGSUB;
    end else if (iw[13:8] == ENC_SWAP) begin
      d.op = OP_SWAP;
    end else if (iw == ENC_HALT) begin
      d.op = OP_HALT;
    end else if (iw[13:3] == ENC_DIRLOAD && iw[2:0] >= DIR_FIRST) begin
      d.op = OP_DIRLOAD;
    end
    return d;
  endfunction

endpackage

// file: design/sss_sub.sv
// Eight-bit subtractor with borrow, half-borrow and zero outputs.
// Assumes purely combinational use inside the execution block.
`timescale 1ns/100ps
module sss_sub (
  // Operands.
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  // Results.
  output logic [7:0] diff,
  output logic no_borrow,
  output logic no_half_borrow,
  output logic is_zero
);
  logic [8:0] full;
  logic [4:0] low;

  assign full = {1'b0, minuend} - {1'b0, subtrahend};
  assign low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
  assign diff = full[7:0];
  assign no_borrow = ~full[8];
  assign no_half_borrow = ~low[4];
  assign is_zero = (full[7:0] == 8'h00);
endmodule

// file: verification/tb_subtract_swap_sleep_exec.sv
// Self-checking testbench for the subtract, swap, direction-load and halt execution block.
// Assumes the block runs each instruction in four cycles after the accepting write.
`timescale 1ns/100ps
module tb_subtract_swap_sleep_exec
  import sss_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [PADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic osc_stop;
  logic [DIR_COUNT*8-1:0] port_dir;
  logic [31:0] rdata;
  logic rerr;
  logic [6:0] st;
  logic [7:0] acc;
  logic [7:0] lit;
  logic [7:0] res;
  int checks = 0;
  int miscompares = 0;
  int cycles = 0;
  logic [7:0] lits [6] = '{8'h02, 8'h02, 8'h02, 8'h10, 8'hFF, 8'h00};
  logic [7:0] accs [6] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h00, 8'hFF};

  sss_exec sss_exec_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .osc_stop(osc_stop),
    .port_dir(port_dir)
  );

  always #25 pclk = ~pclk;

  // About 275 cycles are needed; the ceiling leaves a wide margin.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("mismatch at %0t: run did not finish in time", $time);
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp, what);
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Results land at the fourth edge after the accepting edge; the fifth finds the block idle.
  task automatic instr(input logic [13:0] iw);
    wr(OFS_INSTR, {18'h0, iw});
    repeat (5) @(posedge pclk);
  endtask

  function automatic logic [2:0] flags(input logic [7:0] m, input logic [7:0] s);
    return {m == s, m[3:0] >= s[3:0], m >= s};
  endfunction

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    st = 7'h18;
    rd(OFS_ACC, 32'h0, "acc after reset");
    rd(OFS_STATUS, {25'h0, st}, "status after reset");
    chk({8'h0, port_dir}, 32'h00FFFFFF, "direction after reset");
    chk({31'h0, pready}, 32'h1, "ready after reset");
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      wr(OFS_ACC, {24'h0, accs[i]});
      instr({5'h1E, i[0], lits[i]});
      res = lits[i] - accs[i];
      st[2:0] = flags(lits[i], accs[i]);
      rd(OFS_ACC, {24'h0, res}, "literal subtract result");
      rd(OFS_STATUS, {25'h0, st}, "literal subtract flags");
    end
    $display("test literal subtract done");
    for (int i = 0; i < 2; i++) begin
      lit = i ? 8'h90 : 8'h40;
      acc = i ? 8'h10 : 8'h41;
      wr(OFS_FILE + (i ? 10'h000 : 10'h1FC), {24'h0, lit});
      wr(OFS_ACC, {24'h0, acc});
      instr({6'h02, i[0], i ? 7'h00 : 7'h7F});
      res = lit - acc;
      st[2:0] = flags(lit, acc);
      rd(OFS_ACC, {24'h0, i ? acc : res}, "register subtract acc");
      rd(OFS_FILE + (i ? 10'h000 : 10'h1FC), {24'h0, i ? res : lit}, "register subtract file");
      rd(OFS_STATUS, {25'h0, st}, "register subtract flags");
    end
    $display("test register subtract done");
    wr(OFS_STATUS, 32'h7);
    st = 7'h1F;
    wr(OFS_FILE + 10'h014, 32'hA5);
    instr({6'h0E, 1'b0, 7'h05});
    rd(OFS_ACC, 32'h5A, "swap into acc");
    instr({6'h0E, 1'b1, 7'h05});
    rd(OFS_FILE + 10'h014, 32'h5A, "swap into file");
    rd(OFS_STATUS, {25'h0, st}, "swap leaves flags");
    wr(OFS_INSTR, 32'h0);
    wr(OFS_ACC, 32'h77);
    chk({31'h0, rerr}, 32'h1, "write while busy refused");
    repeat (2) @(posedge pclk);
    rd(OFS_ACC, 32'h5A, "refused write has no effect");
    $display("test swap done");
    wr(OFS_ACC, 32'h3C);
    instr(14'h0064);
    chk({8'h0, port_dir}, 32'h00FFFFFF, "operand 4 is no load");
    instr(14'h0065);
    wr(OFS_ACC, 32'hC3);
    instr(14'h0067);
    chk({8'h0, port_dir}, 32'h00C3FF3C, "direction load");
    rd(OFS_DIR, 32'h3C, "direction 5 read");
    rd(OFS_DIR + 10'h008, 32'hC3, "direction 7 read");
    wr(OFS_DIR + 10'h004, 32'h5A);
    rd(OFS_DIR + 10'h004, 32'h5A, "direction 6 read");
    chk({8'h0, port_dir}, 32'h00C35A3C, "direction 6 written");
    $display("test direction done");
    apb(1'b0, OFS_WDT, 32'h0);
    chk({31'h0, rdata != 32'h0}, 32'h1, "watchdog runs while awake");
    instr(ENC_HALT);
    st = 7'h57;
    rd(OFS_STATUS, {25'h0, st}, "halt status");
    rd(OFS_WDT, 32'h0, "halt clears watchdog");
    chk({31'h0, osc_stop}, 32'h1, "oscillator stopped");
    wr(OFS_INSTR, 32'h0);
    chk({31'h0, rerr}, 32'h1, "instruction while asleep refused");
    wr(OFS_WAKE, 32'h1);
    st = 7'h17;
    rd(OFS_STATUS, {25'h0, st}, "wake status");
    chk({31'h0, osc_stop}, 32'h0, "oscillator restarted");
    $display("test halt done");
    apb(1'b0, 10'h020, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped read refused");
    wr(OFS_WDT, 32'h1);
    chk({31'h0, rerr}, 32'h1, "watchdog write refused");
    $display("test refusal done");
    conclude();
  end
endmodule
